/* File: include/iof_pkg.sv */
// Constants and types shared by the I/O sample frame emitter
package iof_pkg;
  // Host framing bytes and frame types
  localparam logic [7:0] DELIM      = 8'h7E;
  localparam logic [7:0] TYPE_LONG  = 8'h82;
  localparam logic [7:0] TYPE_SHORT = 8'h83;
  localparam logic [7:0] CHK_BASE   = 8'hFF;
  localparam logic [7:0] ADDR_LEN_LONG  = 8'h08;
  localparam logic [7:0] ADDR_LEN_SHORT = 8'h02;

  // Byte offsets, counted from 1 at the start delimiter
  localparam logic [7:0] OFF_DELIM      = 8'h01;
  localparam logic [7:0] OFF_LEN_HI     = 8'h02;
  localparam logic [7:0] OFF_LEN_LO     = 8'h03;
  localparam logic [7:0] OFF_TYPE       = 8'h04;
  localparam logic [7:0] OFF_ADDR       = 8'h05;
  localparam logic [7:0] OFF_RSSI_LONG  = 8'h0D;
  localparam logic [7:0] OFF_OPT_LONG   = 8'h0E;
  localparam logic [7:0] OFF_DATA_LONG  = 8'h0F;
  localparam logic [7:0] OFF_RSSI_SHORT = 8'h07;
  localparam logic [7:0] OFF_OPT_SHORT  = 8'h08;
  localparam logic [7:0] OFF_DATA_SHORT = 8'h09;

  // Options byte fields
  localparam int OPT_ADDR_BCAST_BIT = 1;
  localparam int OPT_PAN_BCAST_BIT  = 2;

  // Payload limits and channel indicator layout
  localparam int         MAX_DATA      = 100;
  localparam logic [7:0] IND_BYTES     = 8'h02;
  localparam int         IND_RSVD_BITS = 3;
  localparam int         ANALOG_BITS   = 4;
  localparam int         DIGITAL_BITS  = 9;
  localparam int         BUF_DEPTH     = 2;

  // Register map on the plain register port
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_FRAMES   = 8'h08;
  localparam int         CTRL_EN_BIT  = 0;
  localparam logic       CTRL_EN_RESET = 1'b1;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_OVF_BIT  = 1;

  // One received I/O sample as presented by the receive path
  typedef struct packed {
    logic                    long_addr;
    logic [63:0]             src_addr;
    logic signed [7:0]       rssi_dbm;
    logic                    bcast_addr;
    logic                    bcast_pan;
    logic [ANALOG_BITS-1:0]  analog_channel_flags;
    logic [DIGITAL_BITS-1:0] digital_channel_flags;
  } iof_sample_t;

  // Framer sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_EMIT = 3'b100
  } iof_fsm_t;
endpackage

/* File: verilog/iof_byte_buffer.sv */
// Small valid/ready FIFO in front of the UART byte sink
`timescale 1ns/1ps
module iof_byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rptr;
    logic [PW-1:0]               wptr;
    logic [CW-1:0]               count;
  } iof_buf_st_t;

  iof_buf_st_t s_q;
  iof_buf_st_t s_d;
  logic        push;
  logic        pop;

  // Honest flags straight from the occupancy count
  assign in_ready  = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = s_q.mem[s_q.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer wrap is explicit so depths other than powers of two work
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data;
      s_d.wptr = (s_q.wptr == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wptr + 1'b1);
    end
    if (pop) begin
      s_d.rptr = (s_q.rptr == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rptr + 1'b1);
    end
    if (push && !pop) begin
      s_d.count = CW'(s_q.count + 1'b1);
    end else if (pop && !push) begin
      s_d.count = CW'(s_q.count - 1'b1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // iof_byte_buffer

/* File: verilog/iof_payload_store.sv */
// Holds the sample bytes of one frame until its length is known
`timescale 1ns/1ps
module iof_payload_store #(
  parameter int DEPTH = 100
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0]            wptr;
  } iof_store_st_t;

  iof_store_st_t s_q;
  iof_store_st_t s_d;

  // Out-of-range reads give zero rather than a stale byte
  assign rd_data = (rd_addr < 8'(DEPTH)) ? s_q.mem[rd_addr] : 8'h00;

  // Writes beyond depth are refused; the framer also stops at the limit
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.wptr = 8'h00;
    end else if (wr_en && (s_q.wptr < 8'(DEPTH))) begin
      s_d.mem[s_q.wptr] = wr_data;
      s_d.wptr = 8'(s_q.wptr + 8'h01);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // iof_payload_store

/* File: verilog/iof_frame_emitter.sv */
// Builds host frames that report a received remote I/O sample
`timescale 1ns/1ps
// Functional notes
// [R1] Long-address sample uses frame type 0x82
// [R2] Long frame: address 5-12, strength 13, options 14
// [R3] Strength byte is magnitude of negative dBm
// [R4] Options bit1 address broadcast, bit2 network broadcast
// [R5] Sample payload at most one hundred bytes
// [R6] Indicator: 3 reserved, 4 analog, 9 digital
// [R7] Short-address sample uses frame type 0x83
// [R8] Short frame: address 5-6, strength 7, options 8
// [R9] Wrap with delimiter, length and checksum
// [R10] Host picks parser and address width by type
module iof_frame_emitter (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                hdr_valid,
  output logic                     hdr_ready,
  input  wire iof_pkg::iof_sample_t hdr,
  input  wire logic                pl_valid,
  output logic                     pl_ready,
  input  wire logic [7:0]          pl_data,
  input  wire logic                pl_last,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic [7:0]               out_data,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  output logic                     busy
);
  // Stream bytes left after the two indicator bytes
  localparam logic [7:0] MAX_STREAM = 8'(iof_pkg::MAX_DATA) - iof_pkg::IND_BYTES;

  typedef struct packed {
    iof_pkg::iof_fsm_t    fsm;
    iof_pkg::iof_sample_t smp;
    logic [7:0]           rssi;
    logic [7:0]           n;
    logic [7:0]           off;
    logic [7:0]           sum;
    logic                 en;
    logic                 ovf;
    logic [31:0]          frames;
    logic [31:0]          rdata;
  } iof_main_st_t;

  iof_main_st_t s_q;
  iof_main_st_t s_d;
  logic         st_clear;
  logic         st_wr;
  logic [7:0]   st_rd_addr;
  logic [7:0]   st_rd_data;
  logic         buf_valid;
  logic         buf_ready;
  logic [7:0]   cur_byte;

  // Magnitude of a negative dBm level; a positive level cannot occur and reads as zero
  function automatic logic [7:0] rssi_mag(input logic signed [7:0] dbm);
    rssi_mag = (dbm < 0) ? 8'(-dbm) : 8'h00; // [R3]
  endfunction

  function automatic logic [7:0] addr_len(input logic long_addr);
    addr_len = long_addr ? iof_pkg::ADDR_LEN_LONG : iof_pkg::ADDR_LEN_SHORT;
  endfunction

  function automatic logic [7:0] rssi_off(input logic long_addr);
    rssi_off = long_addr ? iof_pkg::OFF_RSSI_LONG : iof_pkg::OFF_RSSI_SHORT; // [R2] [R8]
  endfunction

  function automatic logic [7:0] opt_off(input logic long_addr);
    opt_off = long_addr ? iof_pkg::OFF_OPT_LONG : iof_pkg::OFF_OPT_SHORT; // [R2] [R8]
  endfunction

  function automatic logic [7:0] data_off(input logic long_addr);
    data_off = long_addr ? iof_pkg::OFF_DATA_LONG : iof_pkg::OFF_DATA_SHORT; // [R2] [R8]
  endfunction

  // Offset of the checksum byte, which closes the frame
  function automatic logic [7:0] chk_off(input logic long_addr, input logic [7:0] n);
    chk_off = 8'(data_off(long_addr) + iof_pkg::IND_BYTES + n);
  endfunction

  // Byte count from the type byte through the last payload byte
  function automatic logic [7:0] body_len(input logic long_addr, input logic [7:0] n);
    body_len = 8'(chk_off(long_addr, n) - iof_pkg::OFF_TYPE);
  endfunction

  // Selects the frame byte that belongs at a given offset
  function automatic logic [7:0] frame_byte(
    input logic [7:0]           off,
    input iof_pkg::iof_sample_t smp,
    input logic [7:0]           rssi,
    input logic [7:0]           n,
    input logic [7:0]           sum,
    input logic [7:0]           pl_byte
  );
    logic [7:0]  k;
    logic [63:0] addr;
    logic [15:0] ind;
    k    = 8'h00;
    addr = smp.long_addr ? smp.src_addr : {48'h0, smp.src_addr[15:0]};
    // Reserved bits first, then analog 3..0, then digital 8..0
    ind  = {{iof_pkg::IND_RSVD_BITS{1'b0}}, smp.analog_channel_flags,
            smp.digital_channel_flags}; // [R6]
    if (off == iof_pkg::OFF_DELIM) begin
      frame_byte = iof_pkg::DELIM; // [R9]
    end else if (off == iof_pkg::OFF_LEN_HI) begin
      frame_byte = 8'h00; // [R9]
    end else if (off == iof_pkg::OFF_LEN_LO) begin
      frame_byte = body_len(smp.long_addr, n); // [R9]
    end else if (off == iof_pkg::OFF_TYPE) begin
      frame_byte = smp.long_addr ? iof_pkg::TYPE_LONG : iof_pkg::TYPE_SHORT; // [R1] [R7]
    end else if (off < rssi_off(smp.long_addr)) begin
      // Most significant address byte goes out first
      k = 8'(addr_len(smp.long_addr) - 8'h01 - (off - iof_pkg::OFF_ADDR));
      frame_byte = addr[{k[2:0], 3'b000} +: 8]; // [R2] [R8]
    end else if (off == rssi_off(smp.long_addr)) begin
      frame_byte = rssi; // [R3]
    end else if (off == opt_off(smp.long_addr)) begin
      frame_byte = 8'h00;
      frame_byte[iof_pkg::OPT_ADDR_BCAST_BIT] = smp.bcast_addr; // [R4]
      frame_byte[iof_pkg::OPT_PAN_BCAST_BIT]  = smp.bcast_pan; // [R4]
    end else if (off == data_off(smp.long_addr)) begin
      frame_byte = ind[15:8]; // [R6]
    end else if (off == 8'(data_off(smp.long_addr) + 8'h01)) begin
      frame_byte = ind[7:0]; // [R6]
    end else if (off < chk_off(smp.long_addr, n)) begin
      frame_byte = pl_byte;
    end else begin
      frame_byte = 8'(iof_pkg::CHK_BASE - sum); // [R9]
    end
  endfunction

  // Payload read address follows the emit offset
  assign st_rd_addr = 8'(s_q.off - data_off(s_q.smp.long_addr) - iof_pkg::IND_BYTES);
  assign cur_byte   = frame_byte(s_q.off, s_q.smp, s_q.rssi, s_q.n, s_q.sum, st_rd_data);
  assign buf_valid  = (s_q.fsm == iof_pkg::ST_EMIT);
  assign reg_rdata  = s_q.rdata;
  assign busy       = (s_q.fsm != iof_pkg::ST_IDLE);

  // Sequencer, register file and checksum accumulation
  always_comb begin
    s_d       = s_q;
    hdr_ready = 1'b0;
    pl_ready  = 1'b0;
    st_clear  = 1'b0;
    st_wr     = 1'b0;
    s_d.rdata = 32'h0000_0000;
    // Register writes come first so a hardware overflow below wins over the clear
    if (reg_wr) begin
      case (reg_addr)
        iof_pkg::REG_CTRL: s_d.en = reg_wdata[iof_pkg::CTRL_EN_BIT];
        iof_pkg::REG_STATUS: begin
          if (reg_wdata[iof_pkg::STAT_OVF_BIT]) begin
            s_d.ovf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        iof_pkg::REG_CTRL: s_d.rdata[iof_pkg::CTRL_EN_BIT] = s_q.en;
        iof_pkg::REG_STATUS: begin
          s_d.rdata[iof_pkg::STAT_BUSY_BIT] = busy;
          s_d.rdata[iof_pkg::STAT_OVF_BIT]  = s_q.ovf;
        end
        iof_pkg::REG_FRAMES: s_d.rdata = s_q.frames;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    case (s_q.fsm)
      iof_pkg::ST_IDLE: begin
        // Disabling only stops new samples; a frame in flight completes
        hdr_ready = s_q.en;
        if (hdr_valid && s_q.en) begin
          s_d.smp  = hdr;
          s_d.rssi = rssi_mag(hdr.rssi_dbm); // [R3]
          s_d.n    = 8'h00;
          st_clear = 1'b1;
          s_d.fsm  = iof_pkg::ST_LOAD;
        end
      end
      iof_pkg::ST_LOAD: begin
        pl_ready = 1'b1;
        if (pl_valid) begin
          // Bytes past the limit are dropped so the host buffer never overruns
          if (s_q.n < MAX_STREAM) begin
            st_wr = 1'b1; // [R5]
            s_d.n = 8'(s_q.n + 8'h01);
          end else begin
            s_d.ovf = 1'b1; // [R5]
          end
          if (pl_last) begin
            s_d.fsm = iof_pkg::ST_EMIT;
            s_d.off = iof_pkg::OFF_DELIM;
            s_d.sum = 8'h00;
          end
        end
      end
      iof_pkg::ST_EMIT: begin
        if (buf_ready) begin
          // Sum covers the type byte through the last payload byte
          if (s_q.off >= iof_pkg::OFF_TYPE && s_q.off < chk_off(s_q.smp.long_addr, s_q.n)) begin
            s_d.sum = 8'(s_q.sum + cur_byte); // [R9]
          end
          s_d.off = 8'(s_q.off + 8'h01);
          if (s_q.off == chk_off(s_q.smp.long_addr, s_q.n)) begin
            s_d.fsm    = iof_pkg::ST_IDLE;
            s_d.frames = 32'(s_q.frames + 32'h0000_0001);
          end
        end
      end
      default: s_d.fsm = iof_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q     <= '0;
      s_q.fsm <= iof_pkg::ST_IDLE;
      s_q.en  <= iof_pkg::CTRL_EN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Sample bytes wait here until the length field can be sent
  iof_payload_store #(
    .DEPTH (iof_pkg::MAX_DATA)
  ) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (st_clear),
    .wr_en   (st_wr),
    .wr_data (pl_data),
    .rd_addr (st_rd_addr),
    .rd_data (st_rd_data)
  );

  // A receiver stall holds the sequencer, so no byte is lost
  iof_byte_buffer #(
    .WIDTH (8),
    .DEPTH (iof_pkg::BUF_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (buf_valid),
    .in_ready  (buf_ready),
    .in_data   (cur_byte),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );
endmodule // iof_frame_emitter

/* File: testbench/iof_emitter_checker.sv */
// Port-level assertions for the I/O sample frame emitter
`timescale 1ns/1ps
module iof_emitter_checker (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 hdr_valid,
  input wire logic                 hdr_ready,
  input wire iof_pkg::iof_sample_t hdr,
  input wire logic                 pl_valid,
  input wire logic                 pl_ready,
  input wire logic [7:0]           pl_data,
  input wire logic                 pl_last,
  input wire logic                 out_valid,
  input wire logic                 out_ready,
  input wire logic [7:0]           out_data,
  input wire logic [7:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  input wire logic                 busy
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A taken header starts a frame and locks out further headers
  property p_take_busy; hdr_valid && hdr_ready |=> busy; endproperty
  a_take_busy: assert property (p_take_busy) else $error("header taken, not busy");
  property p_refuse; busy |-> !hdr_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("header offered while busy");
  // Stalled byte must stay put, a lost word would corrupt the frame
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_delim;
    hdr_valid && hdr_ready ##1 pl_valid && pl_last
      |-> ##[1:12] out_valid && out_data == iof_pkg::DELIM;
  endproperty
  a_delim: assert property (p_delim) else $error("no start delimiter");
  property p_idle_noload; !busy |-> !pl_ready; endproperty
  a_idle_noload: assert property (p_idle_noload) else $error("payload taken when idle");
  // Read data stands only in the cycle after a read
  property p_quiet; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("read data without read");
  property p_stat;
    reg_rd && reg_addr == iof_pkg::REG_STATUS |=> reg_rdata[0] == $past(busy);
  endproperty
  a_stat: assert property (p_stat) else $error("status busy bit wrong");
  property p_unmap; reg_rd && reg_addr == 8'h0C |=> reg_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_off;
    reg_wr && reg_addr == iof_pkg::REG_CTRL && !reg_wdata[0] |=> !hdr_ready;
  endproperty
  a_off: assert property (p_off) else $error("header ready while disabled");
  // Write, one quiet cycle, then a read of the same place, as the bench issues them
  property p_ctrl_rd;
    reg_wr && reg_addr == iof_pkg::REG_CTRL ##1 !reg_wr
      ##1 reg_rd && reg_addr == iof_pkg::REG_CTRL
      |=> reg_rdata[0] == $past(reg_wdata[0], 3);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("enable readback wrong");
endmodule // iof_emitter_checker

/* File: testbench/iof_host_model.sv */
// Host side model that drains frame bytes from the UART sink
`timescale 1ns/1ps
module iof_host_model (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       stall,
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  output logic           out_ready
);
  logic [7:0] got[$];
  logic [1:0] phase_q;
  // Skip one cycle in three so the buffer sees back-pressure
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    end
  end
  assign out_ready = !stall && (phase_q != 2'h2);
  // Bytes kept in arrival order for the parser
  always @(posedge sys_clk) begin
    if (!rst && out_valid && out_ready) got.push_back(out_data);
  end
endmodule // iof_host_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the I/O sample frame emitter
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst, hdr_valid, pl_valid, pl_last, reg_wr, reg_rd, stall;
  logic hdr_ready, pl_ready, out_valid, out_ready, busy;
  logic [7:0] pl_data, out_data, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  iof_pkg::iof_sample_t hdr;
  int err_count, tests_run, cyc;

  iof_frame_emitter DUT (.sys_clk(sys_clk), .rst(rst), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .hdr(hdr), .pl_valid(pl_valid), .pl_ready(pl_ready),
    .pl_data(pl_data), .pl_last(pl_last), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));
  iof_host_model host (.sys_clk(sys_clk), .rst(rst), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

  // Free-running clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register accesses; each ends one edge later so strobes never double up
  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask

  // Offer one sample with n payload bytes, then parse the frame the host saw
  task automatic send(input iof_pkg::iof_sample_t s, input int n, input int st);
    logic [7:0] exp[$];
    logic [7:0] sum;
    int a, k, i;
    a = s.long_addr ? 8 : 2;
    k = (n > 98) ? 98 : n;
    exp = '{iof_pkg::DELIM, 8'h00, 8'(a + 5 + k),
            s.long_addr ? iof_pkg::TYPE_LONG : iof_pkg::TYPE_SHORT};
    for (i = a - 1; i >= 0; i--) exp.push_back(s.src_addr[8*i +: 8]);
    exp.push_back(s.rssi_dbm < 0 ? 8'(-s.rssi_dbm) : 8'h00);
    exp.push_back({5'h00, s.bcast_pan, s.bcast_addr, 1'b0});
    exp.push_back({3'h0, s.analog_channel_flags, s.digital_channel_flags[8]});
    exp.push_back(s.digital_channel_flags[7:0]);
    for (i = 0; i < k; i++) exp.push_back(8'(i + 8'h30));
    sum = 8'h00;
    for (i = 3; i < exp.size(); i++) sum += exp[i];
    exp.push_back(8'hFF - sum);
    stall <= (st > 0);
    hdr <= s;
    hdr_valid <= 1'b1;
    @(negedge sys_clk);
    while (hdr_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    hdr_valid <= 1'b0;
    for (i = 0; i < n; i++) begin
      pl_valid <= 1'b1;
      pl_data <= 8'(i + 8'h30);
      pl_last <= (i == n - 1);
      @(negedge sys_clk);
      while (pl_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    pl_valid <= 1'b0;
    pl_last <= 1'b0;
    repeat (st) @(posedge sys_clk);
    if (st > 0) check(32'(out_valid), 32'h1);
    stall <= 1'b0;
    for (i = 0; i < 2000 && host.got.size() < exp.size(); i++) @(posedge sys_clk);
    a = (host.got[3] == iof_pkg::TYPE_LONG) ? 12 : 6;
    check(32'(host.got[3]), 32'(exp[3]));
    check(32'(host.got[a]), 32'(exp[a]));
    check(32'(host.got[a + 1]), 32'(exp[a + 1]));
    check(32'(host.got[a + 2][7:5]), 32'h0);
    check(32'(host.got.size() - 4), 32'(exp[2]));
    for (i = 0; i < exp.size(); i++) check(32'(host.got[i]), 32'(exp[i]));
    host.got.delete();
    while (busy !== 1'b0) @(posedge sys_clk);
  endtask

  initial begin
    rst <= 1'b1;
    {hdr_valid, pl_valid, pl_last, reg_wr, reg_rd, stall} <= 6'h00;
    {pl_data, reg_addr, reg_wdata} <= 48'h0;
    hdr <= '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values and an unmapped place
    reg_read(iof_pkg::REG_CTRL, d);
    check(d, 32'h1);
    reg_read(iof_pkg::REG_STATUS, d);
    check(d, 32'h0);
    reg_read(iof_pkg::REG_FRAMES, d);
    check(d, 32'h0);
    reg_write(8'h0C, 32'hFFFF_FFFF);
    reg_read(8'h0C, d);
    check(d, 32'h0);
    $display("test registers done");
    // Long address, address broadcast, one payload byte
    send('{1'b1, 64'h1122_3344_5566_7788, -8'sd40, 1'b1, 1'b0, 4'hA, 9'h155}, 1, 0);
    $display("test long frame done");
    // Short address, network broadcast, only low address bytes count
    send('{1'b0, 64'hFFFF_FFFF_FFFF_BEEF, -8'sd1, 1'b0, 1'b1, 4'h5, 9'h1FF}, 3, 0);
    $display("test short frame done");
    // Oversized payload under a long stall, positive strength reads zero
    send('{1'b1, 64'h0102_0304_0506_0708, 8'sd5, 1'b1, 1'b1, 4'hF, 9'h000}, 100, 40);
    reg_read(iof_pkg::REG_STATUS, d);
    check(d, 32'h2);
    reg_write(iof_pkg::REG_STATUS, 32'h2);
    reg_read(iof_pkg::REG_STATUS, d);
    check(d, 32'h0);
    reg_read(iof_pkg::REG_FRAMES, d);
    check(d, 32'h3);
    $display("test overflow done");
    // Disabled block refuses headers and sends nothing
    reg_write(iof_pkg::REG_CTRL, 32'h0);
    reg_read(iof_pkg::REG_CTRL, d);
    check(d, 32'h0);
    hdr_valid <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(32'(hdr_ready), 32'h0);
    check(32'(host.got.size()), 32'h0);
    hdr_valid <= 1'b0;
    reg_write(iof_pkg::REG_CTRL, 32'h1);
    check(32'(hdr_ready), 32'h1);
    $display("test disable done");
    tally_and_finish();
  end
endmodule // tb_top

bind iof_frame_emitter iof_emitter_checker chk (.sys_clk(sys_clk), .rst(rst),
  .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr(hdr), .pl_valid(pl_valid),
  .pl_ready(pl_ready), .pl_data(pl_data), .pl_last(pl_last), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));
